// file: logic/ric_reset_interrupt_control.sv
// reset merging, external interrupt pin, interrupt priority and vectors
// assumes the cpu sequencer, peripherals and bus master run on I_CORE_CLK;
// only the reset pin and the interrupt pin are asynchronous
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps

// Contract
// [R1] every reset kind drives the reset vector and sets the cpu mask bit
// [R2] power-on holds reset 4064 cycles after the oscillator starts
// [R3] reset pin still low at end of power-on delay extends reset
// [R4] no reset path for a falling supply
// [R5] outside agent holds reset pin low at least 1.5 bus cycles
// [R6] reset sequence starts at first clock edge after reset pin rises; code releases reset at the third edge, after the two synchroniser flops
// [R7] opcode fetch from unused space or i/o space causes internal reset
// [R8] illegal-address reset keeps the current operating mode
// [R9] writing zero to bit 0 of service address clears watchdog; timeout resets
// [R10] watchdog reset cannot be disabled
// [R11] mask bit set blocks every maskable request; clear lets them through
// [R12] accepted interrupt stacks registers and sets mask; return restores them
// [R13] hardware requests wait for instruction end, taken only if mask clear
// [R14] software interrupt ignores mask, follows requests pending at its fetch
// [R15] priority reset, software, pin, sync, bus, timer, each own vector
// [R16] edge-only select 1 gives falling edge only, 0 level plus edge
// [R17] pin interrupt accepted: stack, set mask, use pin vector
// [R18] pin latch cleared at service so one more edge can be held
// [R19] edge-only sources space pulses beyond service routine plus 21 cycles
// [R20] level mode rerequests while pin stays low after a service
// [R21] sync request gated by sync enable bit 7, latch cleared at vector fetch
// [R22] bus request passes only with its enable set and mask clear
// [R23] timer flags request only with own enables; cleared by writing zero
// [R24] highest pending request served first, others stay pending
module ric_reset_interrupt_control #(
	parameter int POR_CYCLES = ric_pkg::POR_DELAY_CYCLES,
	parameter int INT_RESET_CYCLES = ric_pkg::INT_RESET_CYCLES_DEF,
	parameter logic [13:0] RAM_FIRST = ric_pkg::RAM_FIRST_DEF,
	parameter logic [13:0] RAM_LAST = ric_pkg::RAM_LAST_DEF,
	parameter logic [13:0] ROM_FIRST = ric_pkg::ROM_FIRST_DEF,
	parameter logic [13:0] ROM_LAST = ric_pkg::ROM_LAST_DEF
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RESETN,
	// pins
	input wire logic I_RESET_PIN_N,
	input wire logic I_IRQ_PIN_N,
	// cpu sequencer
	input wire logic I_FETCH,
	input wire logic [ric_pkg::CPU_ADDR_W-1:0] I_FETCH_ADDR,
	input wire logic I_CPU_WRITE,
	input wire logic [ric_pkg::CPU_ADDR_W-1:0] I_CPU_ADDR,
	input wire logic [7:0] I_CPU_WDATA,
	input wire logic I_INSTR_DONE,
	input wire logic I_MASK_BIT,
	input wire logic I_SWI_FETCH,
	// peripherals
	input wire logic I_WATCHDOG_TIMEOUT,
	input wire logic I_VSYNC_EVENT,
	input wire logic I_SERIAL_BUS_FLAG,
	input wire logic I_OVERFLOW_EVENT,
	input wire logic I_PERIODIC_EVENT,
	// avalon-mm slave
	input wire logic [ric_pkg::AVS_ADDR_W-1:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	// to cpu and peripherals
	output logic O_CPU_RESET,
	output logic O_KEEP_MODE,
	output logic O_SET_MASK,
	output logic O_SERVICE,
	output logic [ric_pkg::CPU_ADDR_W-1:0] O_VECTOR_ADDR,
	output logic O_WATCHDOG_CLEAR,
	output logic [1:0] O_RATE_SELECT
);
	import ric_pkg::*;

	localparam int POR_CNT_W = $clog2(POR_CYCLES + 1);
	localparam int INT_CNT_W = $clog2(INT_RESET_CYCLES + 1);
	localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES - 1);
	localparam logic [INT_CNT_W-1:0] INT_LAST = INT_CNT_W'(INT_RESET_CYCLES - 1);

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [NUM_HW-1:0] lowest_one(input logic [NUM_HW-1:0] req);
		lowest_one = req & (~req + NUM_HW'(1));
	endfunction

	function automatic logic [13:0] hw_vector(input logic [NUM_HW-1:0] onehot);
		logic [13:0] v;
		v = VEC_TIMER;
		if (onehot[SRC_EXT]) begin
			v = VEC_EXT;
		end else if (onehot[SRC_SYNC]) begin
			v = VEC_SYNC;
		end else if (onehot[SRC_BUS]) begin
			v = VEC_BUS;
		end
		hw_vector = v;
	endfunction

	function automatic logic in_range(input logic [13:0] a, input logic [13:0] lo, input logic [13:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic rst_meta_ff;
	logic rst_sync_ff;
	logic irq_meta_ff;
	logic irq_sync_ff;
	logic irq_prev_ff;

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
			irq_meta_ff <= 1'b1;
			irq_sync_ff <= 1'b1;
			irq_prev_ff <= 1'b1;
		end else begin
			rst_meta_ff <= I_RESET_PIN_N;
			rst_sync_ff <= rst_meta_ff;
			irq_meta_ff <= I_IRQ_PIN_N;
			irq_sync_ff <= irq_meta_ff;
			irq_prev_ff <= irq_sync_ff;
		end
	end

	// pulses shorter than one clock can slip through the sync stage
	wire pin_low = !rst_sync_ff; // [R5]
	wire irq_fall = irq_prev_ff && !irq_sync_ff;

	// ----------------------------------------------------------------
	// reset sequencer
	// ----------------------------------------------------------------
	// only I_RESETN (supply up) enters the power state; nothing watches a
	// falling supply, so a brown-out is not caught here
	ric_rst_state_t rst_state_ff; // [R4]
	ric_rst_state_t nxt_rst_state;
	logic [POR_CNT_W-1:0] por_cnt_ff;
	logic [INT_CNT_W-1:0] int_cnt_ff;
	logic [3:0] cause_ff;
	logic [3:0] nxt_cause;

	wire running = (rst_state_ff == RST_RUN);
	wire illegal_fetch = I_FETCH &&
		!(in_range(I_FETCH_ADDR, RAM_FIRST, RAM_LAST) || in_range(I_FETCH_ADDR, ROM_FIRST, ROM_LAST)); // [R7]
	wire por_done = (por_cnt_ff == POR_LAST);
	wire int_done = (int_cnt_ff == INT_LAST);

	always_comb begin
		nxt_rst_state = rst_state_ff;
		nxt_cause = cause_ff;
		unique case (rst_state_ff)
			RST_POWER: begin
				if (por_done) begin // [R2]
					nxt_rst_state = pin_low ? RST_PIN : RST_RUN; // [R3]
				end
			end
			RST_PIN: begin
				if (!pin_low) begin
					nxt_rst_state = RST_RUN; // [R6]
				end
			end
			RST_INTERNAL: begin
				if (pin_low) begin
					nxt_rst_state = RST_PIN;
					nxt_cause = 4'(1 << CAUSE_PIN);
				end else if (int_done) begin
					nxt_rst_state = RST_RUN;
				end
			end
			RST_RUN: begin
				if (pin_low) begin
					nxt_rst_state = RST_PIN;
					nxt_cause = 4'(1 << CAUSE_PIN);
				end else if (illegal_fetch) begin
					nxt_rst_state = RST_INTERNAL; // [R7]
					nxt_cause = 4'(1 << CAUSE_ILLEGAL);
				end else if (I_WATCHDOG_TIMEOUT) begin
					// no enable term: the watchdog can never be switched off
					nxt_rst_state = RST_INTERNAL; // [R9] [R10]
					nxt_cause = 4'(1 << CAUSE_WDOG);
				end
			end
		endcase
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rst_state_ff <= RST_POWER;
			cause_ff <= CAUSE_RESET;
		end else begin
			rst_state_ff <= nxt_rst_state;
			cause_ff <= nxt_cause;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			por_cnt_ff <= '0;
		end else if (rst_state_ff == RST_POWER && !por_done) begin
			por_cnt_ff <= por_cnt_ff + POR_CNT_W'(1); // [R2]
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			int_cnt_ff <= '0;
		end else if (rst_state_ff == RST_INTERNAL) begin
			int_cnt_ff <= int_cnt_ff + INT_CNT_W'(1);
		end else begin
			int_cnt_ff <= '0;
		end
	end

	// ----------------------------------------------------------------
	// register decode
	// ----------------------------------------------------------------
	logic waitreq_ff;
	logic [31:0] readdata_ff;
	logic [7:0] tcs_ctl_ff;
	logic tof_ff;
	logic periodic_interrupt_flag_ff;
	logic sync_en_ff;
	logic bus_en_ff;

	wire bus_req = I_AVS_READ || I_AVS_WRITE;
	wire commit = I_AVS_WRITE && !waitreq_ff && I_AVS_BYTEENABLE[0];
	wire wr_tcs = commit && (I_AVS_ADDRESS == REG_TCS);
	wire wr_sync = commit && (I_AVS_ADDRESS == REG_SYNC_CTL);
	wire wr_bus = commit && (I_AVS_ADDRESS == REG_BUS_CTL);
	wire [7:0] wdata8 = I_AVS_WRITEDATA[7:0];
	wire edge_only = tcs_ctl_ff[TCS_EDGE];

	// ----------------------------------------------------------------
	// request latches
	// ----------------------------------------------------------------
	logic ext_latch_ff;
	logic vsync_latch_ff;
	logic swi_pend_ff;
	logic [NUM_HW-1:0] snap_ff;
	logic [NUM_HW-1:0] served;
	logic serve_swi;

	// edge mode holds one fall at a time; level mode also sees a held low
	wire ext_req = ext_latch_ff || (!edge_only && !irq_sync_ff); // [R16] [R20]
	wire sync_req = vsync_latch_ff && sync_en_ff; // [R21]
	wire bus_int_req = I_SERIAL_BUS_FLAG && bus_en_ff; // [R22]
	wire timer_req = (tof_ff && tcs_ctl_ff[TCS_OVERFLOW_INTERRUPT_ENABLE]) || (periodic_interrupt_flag_ff && tcs_ctl_ff[TCS_PERIODIC_INTERRUPT_ENABLE]); // [R23]
	wire [NUM_HW-1:0] hw_req = {timer_req, bus_int_req, sync_req, ext_req};
	wire boundary = running && I_INSTR_DONE; // [R13]
	wire [NUM_HW-1:0] early_req = hw_req & snap_ff;
	// mask is checked only for hardware sources
	wire [NUM_HW-1:0] open_req = I_MASK_BIT ? '0 : hw_req; // [R11] [R22]
	wire [NUM_HW-1:0] open_early = I_MASK_BIT ? '0 : early_req; // [R14]

	always_comb begin
		served = '0;
		serve_swi = 1'b0;
		if (boundary) begin
			if (swi_pend_ff) begin
				if (|open_early) begin
					served = lowest_one(open_early); // [R14] [R24]
				end else begin
					serve_swi = 1'b1; // [R14]
				end
			end else if (|open_req) begin
				served = lowest_one(open_req); // [R15] [R24]
			end
		end
	end

	wire take = serve_swi || (|served);
	wire [13:0] take_vector = serve_swi ? VEC_SWI : hw_vector(served); // [R15] [R17]

	// a new edge in the clearing cycle wins over the clear
	wire nxt_ext_latch = running && (irq_fall || (ext_latch_ff && !served[SRC_EXT])); // [R18]
	wire nxt_vsync_latch = running && (I_VSYNC_EVENT || (vsync_latch_ff && !served[SRC_SYNC])); // [R21]
	wire nxt_swi_pend = running && (I_SWI_FETCH || (swi_pend_ff && !serve_swi));
	wire [NUM_HW-1:0] nxt_snap = I_SWI_FETCH ? hw_req : (snap_ff & ~served);

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ext_latch_ff <= 1'b0;
			vsync_latch_ff <= 1'b0;
			swi_pend_ff <= 1'b0;
			snap_ff <= '0;
		end else begin
			ext_latch_ff <= nxt_ext_latch;
			vsync_latch_ff <= nxt_vsync_latch;
			swi_pend_ff <= nxt_swi_pend;
			snap_ff <= nxt_snap;
		end
	end

	// ----------------------------------------------------------------
	// timer control and status, enables
	// ----------------------------------------------------------------
	// flags clear only on a written zero; a set in the same cycle wins
	wire nxt_tof = I_OVERFLOW_EVENT || (tof_ff && !(wr_tcs && !wdata8[TCS_TOF])); // [R23]
	wire nxt_periodic_interrupt_flag = I_PERIODIC_EVENT || (periodic_interrupt_flag_ff && !(wr_tcs && !wdata8[TCS_PERIODIC_INTERRUPT_FLAG])); // [R23]

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			tcs_ctl_ff <= TCS_RESET & TCS_CTL_MASK;
			tof_ff <= 1'b0;
			periodic_interrupt_flag_ff <= 1'b0;
			sync_en_ff <= 1'b0;
			bus_en_ff <= 1'b0;
		end else begin
			tof_ff <= nxt_tof;
			periodic_interrupt_flag_ff <= nxt_periodic_interrupt_flag;
			if (wr_tcs) begin
				tcs_ctl_ff <= wdata8 & TCS_CTL_MASK; // [R16]
			end
			if (wr_sync) begin
				sync_en_ff <= wdata8[SYNC_EN_BIT];
			end
			if (wr_bus) begin
				bus_en_ff <= wdata8[BUS_EN_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// avalon-mm slave: one wait cycle, data staged at the first edge
	// ----------------------------------------------------------------
	logic [7:0] rd_sel;

	wire [7:0] tcs_view = {tof_ff, periodic_interrupt_flag_ff, tcs_ctl_ff[5:0]};
	wire [7:0] pending_view = {3'h0, swi_pend_ff, hw_req};

	always_comb begin
		rd_sel = 8'h00;
		unique case (I_AVS_ADDRESS)
			REG_TCS: rd_sel = tcs_view;
			REG_SYNC_CTL: rd_sel = 8'(sync_en_ff) << SYNC_EN_BIT;
			REG_BUS_CTL: rd_sel = 8'(bus_en_ff) << BUS_EN_BIT;
			REG_RESET_CAUSE: rd_sel = {4'h0, cause_ff};
			REG_PENDING: rd_sel = pending_view;
			default: rd_sel = 8'h00;
		endcase
	end

	wire nxt_waitreq = !(bus_req && waitreq_ff);

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			waitreq_ff <= 1'b1;
			readdata_ff <= 32'h0000_0000;
		end else begin
			waitreq_ff <= nxt_waitreq;
			if (I_AVS_READ && waitreq_ff) begin
				readdata_ff <= {24'h00_0000, rd_sel};
			end
		end
	end

	assign O_AVS_WAITREQUEST = waitreq_ff;
	assign O_AVS_READDATA = readdata_ff;

	// ----------------------------------------------------------------
	// cpu outputs
	// ----------------------------------------------------------------
	logic cpu_reset_ff;
	logic keep_mode_ff;
	logic set_mask_ff;
	logic service_ff;
	logic [13:0] vector_ff;
	logic wdog_clear_ff;

	wire in_reset_next = (nxt_rst_state != RST_RUN);
	wire wdog_kick = running && I_CPU_WRITE && (I_CPU_ADDR == WDOG_SERVICE_ADDR) &&
		!I_CPU_WDATA[WDOG_SERVICE_BIT]; // [R9]

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			cpu_reset_ff <= 1'b1;
			keep_mode_ff <= 1'b0;
			set_mask_ff <= 1'b1;
			service_ff <= 1'b0;
			vector_ff <= VEC_RESET;
			wdog_clear_ff <= 1'b0;
		end else begin
			cpu_reset_ff <= in_reset_next; // [R1]
			keep_mode_ff <= (nxt_rst_state == RST_INTERNAL); // [R8] [R9]
			// the cpu stacks its registers on the service pulse and restores
			// them itself on return
			set_mask_ff <= in_reset_next || take; // [R1] [R12] [R17]
			service_ff <= take && !in_reset_next; // [R12] [R13]
			wdog_clear_ff <= wdog_kick;
			if (in_reset_next) begin
				vector_ff <= VEC_RESET; // [R1] [R15]
			end else if (take) begin
				vector_ff <= take_vector; // [R15] [R17]
			end
		end
	end

	assign O_CPU_RESET = cpu_reset_ff;
	assign O_KEEP_MODE = keep_mode_ff;
	assign O_SET_MASK = set_mask_ff;
	assign O_SERVICE = service_ff;
	assign O_VECTOR_ADDR = vector_ff;
	assign O_WATCHDOG_CLEAR = wdog_clear_ff;
	assign O_RATE_SELECT = tcs_ctl_ff[TCS_RATE_HI:TCS_RATE_LO];

endmodule

// file: logic/ric_pkg.sv
// constants, register map and types of the reset and interrupt control block
// assumes one core clock; the cpu sequencer and peripherals share that clock
package ric_pkg;
	// ----------------------------------------------------------------
	// cpu address space
	// ----------------------------------------------------------------
	localparam int CPU_ADDR_W = 14;
	localparam logic [13:0] VEC_RESET = 14'h3ffe;
	localparam logic [13:0] VEC_SWI = 14'h3ffc;
	localparam logic [13:0] VEC_EXT = 14'h3ffa;
	localparam logic [13:0] VEC_SYNC = 14'h3ff8;
	localparam logic [13:0] VEC_BUS = 14'h3ff6;
	localparam logic [13:0] VEC_TIMER = 14'h3ff4;
	localparam logic [13:0] WDOG_SERVICE_ADDR = 14'h3ff0;
	localparam int WDOG_SERVICE_BIT = 0;
	// legal fetch ranges; i/o registers sit below ram and are never legal
	localparam logic [13:0] RAM_FIRST_DEF = 14'h0040;
	localparam logic [13:0] RAM_LAST_DEF = 14'h00ff;
	localparam logic [13:0] ROM_FIRST_DEF = 14'h0100;
	localparam logic [13:0] ROM_LAST_DEF = 14'h3fff;
	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	localparam int AVS_ADDR_W = 8;
	localparam logic [7:0] REG_TCS = 8'h08;
	localparam logic [7:0] REG_SYNC_CTL = 8'h0c;
	localparam logic [7:0] REG_BUS_CTL = 8'h10;
	localparam logic [7:0] REG_RESET_CAUSE = 8'h14;
	localparam logic [7:0] REG_PENDING = 8'h18;
	localparam int TCS_TOF = 7;
	localparam int TCS_PERIODIC_INTERRUPT_FLAG = 6;
	localparam int TCS_OVERFLOW_INTERRUPT_ENABLE = 5;
	localparam int TCS_PERIODIC_INTERRUPT_ENABLE = 4;
	localparam int TCS_EDGE = 3;
	localparam int TCS_RATE_LO = 0;
	localparam int TCS_RATE_HI = 1;
	localparam logic [7:0] TCS_RESET = 8'h03;
	localparam logic [7:0] TCS_CTL_MASK = 8'h3b;
	localparam int SYNC_EN_BIT = 7;
	localparam int BUS_EN_BIT = 0;
	localparam int CAUSE_POR = 0;
	localparam int CAUSE_PIN = 1;
	localparam int CAUSE_ILLEGAL = 2;
	localparam int CAUSE_WDOG = 3;
	localparam logic [3:0] CAUSE_RESET = 4'h1;
	// ----------------------------------------------------------------
	// sources, counts, states
	// ----------------------------------------------------------------
	localparam int NUM_HW = 4;
	localparam int SRC_EXT = 0;
	localparam int SRC_SYNC = 1;
	localparam int SRC_BUS = 2;
	localparam int SRC_TIMER = 3;
	localparam int POR_DELAY_CYCLES = 4064;
	localparam int INT_RESET_CYCLES_DEF = 4;
	typedef enum logic [1:0] {
		RST_POWER = 2'b00,
		RST_PIN = 2'b01,
		RST_INTERNAL = 2'b10,
		RST_RUN = 2'b11
	} ric_rst_state_t;
endpackage

// file: verification/ric_sva.sv
// port checks of the reset and interrupt control block
// assumes a bind onto ric_reset_interrupt_control, one clock domain
`timescale 1ns/1ps
module ric_sva
	import ric_pkg::*;
#(
	parameter int POR_CYCLES = ric_pkg::POR_DELAY_CYCLES,
	parameter logic [13:0] RAM_FIRST = ric_pkg::RAM_FIRST_DEF,
	parameter logic [13:0] RAM_LAST = ric_pkg::RAM_LAST_DEF,
	parameter logic [13:0] ROM_FIRST = ric_pkg::ROM_FIRST_DEF,
	parameter logic [13:0] ROM_LAST = ric_pkg::ROM_LAST_DEF
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RESETN,
	input wire logic I_RESET_PIN_N,
	input wire logic I_FETCH,
	input wire logic [ric_pkg::CPU_ADDR_W-1:0] I_FETCH_ADDR,
	input wire logic I_CPU_WRITE,
	input wire logic [ric_pkg::CPU_ADDR_W-1:0] I_CPU_ADDR,
	input wire logic [7:0] I_CPU_WDATA,
	input wire logic I_INSTR_DONE,
	input wire logic I_MASK_BIT,
	input wire logic I_WATCHDOG_TIMEOUT,
	input wire logic O_CPU_RESET,
	input wire logic O_KEEP_MODE,
	input wire logic O_SET_MASK,
	input wire logic O_SERVICE,
	input wire logic [ric_pkg::CPU_ADDR_W-1:0] O_VECTOR_ADDR,
	input wire logic O_WATCHDOG_CLEAR
);
	// ----------------
	// helper logic
	// ----------------
	// saturating, so the power-on window is seen once per release
	logic [15:0] up_cnt_ff;
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			up_cnt_ff <= 16'h0000;
		end else if (up_cnt_ff != 16'hffff) begin
			up_cnt_ff <= up_cnt_ff + 16'h0001;
		end
	end
	wire in_ram = I_FETCH_ADDR >= RAM_FIRST && I_FETCH_ADDR <= RAM_LAST;
	wire in_rom = I_FETCH_ADDR >= ROM_FIRST && I_FETCH_ADDR <= ROM_LAST;
	wire fetch_bad = I_FETCH && !in_ram && !in_rom;
	wire kick_raw = I_CPU_WRITE && I_CPU_ADDR == WDOG_SERVICE_ADDR && !I_CPU_WDATA[WDOG_SERVICE_BIT];
	// ----------------
	// assertions
	// ----------------
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESETN);
	a_reset_vector: assert property (O_CPU_RESET |-> O_VECTOR_ADDR == VEC_RESET && O_SET_MASK)
		else $error("reset without reset vector or mask");
	a_por_hold: assert property (up_cnt_ff < POR_CYCLES - 1 |-> O_CPU_RESET)
		else $error("reset left before power-on delay");
	a_pin_hold: assert property (!I_RESET_PIN_N [*4] |=> O_CPU_RESET)
		else $error("reset pin low but cpu running");
	a_pin_release: assert property ($rose(I_RESET_PIN_N) && up_cnt_ff > POR_CYCLES && !O_KEEP_MODE
		|-> ##[1:4] !O_CPU_RESET)
		else $error("reset not released after pin rise");
	a_illegal_rst: assert property (fetch_bad && !O_CPU_RESET |=> O_CPU_RESET && O_KEEP_MODE)
		else $error("illegal fetch without internal reset");
	a_wdog_rst: assert property (I_WATCHDOG_TIMEOUT && !O_CPU_RESET |=> O_CPU_RESET && O_KEEP_MODE)
		else $error("watchdog timeout without internal reset");
	a_wdog_kick: assert property (kick_raw && !O_CPU_RESET |=> O_WATCHDOG_CLEAR)
		else $error("service write did not clear watchdog");
	a_kick_cause: assert property (O_WATCHDOG_CLEAR |-> $past(kick_raw))
		else $error("watchdog clear without service write");
	a_mask_gate: assert property (O_SERVICE && O_VECTOR_ADDR != VEC_SWI
		|-> $past(I_INSTR_DONE) && !$past(I_MASK_BIT))
		else $error("hardware service while masked or mid instruction");
	a_service_pulse: assert property (O_SERVICE |-> O_SET_MASK ##1 !O_SERVICE)
		else $error("service pulse malformed");
endmodule

bind ric_reset_interrupt_control ric_sva #(.POR_CYCLES(POR_CYCLES), .RAM_FIRST(RAM_FIRST), .RAM_LAST(RAM_LAST),
	.ROM_FIRST(ROM_FIRST), .ROM_LAST(ROM_LAST)) i_sva (.I_CORE_CLK, .I_RESETN, .I_RESET_PIN_N, .I_FETCH,
	.I_FETCH_ADDR, .I_CPU_WRITE, .I_CPU_ADDR, .I_CPU_WDATA, .I_INSTR_DONE, .I_MASK_BIT, .I_WATCHDOG_TIMEOUT,
	.O_CPU_RESET, .O_KEEP_MODE, .O_SET_MASK, .O_SERVICE, .O_VECTOR_ADDR, .O_WATCHDOG_CLEAR);

// file: verification/ric_cpu_model.sv
// cpu sequencer model: instruction boundaries and the interrupt mask bit
// assumes the block's service and set-mask pulses on the same clock
`timescale 1ns/1ps
module ric_cpu_model (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_cpu_reset,
	input wire logic i_set_mask,
	input wire logic i_return,
	output logic o_instr_done,
	output logic o_mask
);
	// ----------------
	// sequencer
	// ----------------
	// four-cycle instructions; no boundary while held in reset
	logic [1:0] phase_ff;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			phase_ff <= 2'b00;
			o_instr_done <= 1'b0;
			o_mask <= 1'b1;
		end else begin
			phase_ff <= i_cpu_reset ? 2'b00 : phase_ff + 2'b01;
			o_instr_done <= !i_cpu_reset && phase_ff == 2'b11;
			o_mask <= i_set_mask | (o_mask & !i_return);
		end
	end
endmodule

// file: verification/testbench.sv
// self-checking bench for the reset and interrupt control block
// assumes the cpu model file is compiled beside it; short power-on count
`timescale 1ns/1ps
module testbench;
	import ric_pkg::*;
	localparam int POR = 8;
	logic clk = 1'b0;
	logic resetn = 1'b0, pin_n = 1'b0, irq_n = 1'b1, fetch = 1'b0, cpu_wr = 1'b0, sbus = 1'b0;
	logic avs_rd = 1'b0, avs_wr = 1'b0, instr_done, mask, cpu_rst, keep, set_mask, svc, waitreq, wclr;
	logic [5:0] ev = 6'h00;
	logic [13:0] fetch_addr = 14'h0100, cpu_addr = 14'h0000, vec;
	logic [7:0] cpu_wdata = 8'h00, avs_addr = 8'h00;
	logic [31:0] avs_wd = 32'h0, rdata, r;
	logic [3:0] avs_be = 4'hf;
	logic [1:0] rate;
	logic [31:0] rd_q[$];
	logic [13:0] vq[$];
	int num_errors = 0, samples_checked = 0, svc_cnt = 0, t = 0, seed = 32'h6ed11d11;
	always #25 clk = ~clk;
	ric_reset_interrupt_control #(.POR_CYCLES(POR)) i_dut (.I_CORE_CLK(clk), .I_RESETN(resetn),
		.I_RESET_PIN_N(pin_n), .I_IRQ_PIN_N(irq_n), .I_FETCH(fetch), .I_FETCH_ADDR(fetch_addr),
		.I_CPU_WRITE(cpu_wr), .I_CPU_ADDR(cpu_addr), .I_CPU_WDATA(cpu_wdata), .I_INSTR_DONE(instr_done),
		.I_MASK_BIT(mask), .I_SWI_FETCH(ev[1]), .I_WATCHDOG_TIMEOUT(ev[5]), .I_VSYNC_EVENT(ev[2]),
		.I_SERIAL_BUS_FLAG(sbus), .I_OVERFLOW_EVENT(ev[3]), .I_PERIODIC_EVENT(ev[4]), .I_AVS_ADDRESS(avs_addr),
		.I_AVS_READ(avs_rd), .I_AVS_WRITE(avs_wr), .I_AVS_WRITEDATA(avs_wd), .I_AVS_BYTEENABLE(avs_be),
		.O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq), .O_CPU_RESET(cpu_rst), .O_KEEP_MODE(keep),
		.O_SET_MASK(set_mask), .O_SERVICE(svc), .O_VECTOR_ADDR(vec), .O_WATCHDOG_CLEAR(wclr),
		.O_RATE_SELECT(rate));
	ric_cpu_model i_cpu (.i_clk(clk), .i_resetn(resetn), .i_cpu_reset(cpu_rst), .i_set_mask(set_mask),
		.i_return(ev[0]), .o_instr_done(instr_done), .o_mask(mask));
	// ----------------
	// checking
	// ----------------
	task test_done;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task timed_out;
		num_errors++;
		$display("Error wait timed out");
		test_done();
	endtask
	task check_vec(input logic [13:0] exp, input logic [13:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error vector expected %h seen %h", exp, got);
		end
	endtask
	task check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// an empty note queue means the service was not expected at all
	always @(posedge clk) begin
		if (avs_rd === 1'b1 && waitreq === 1'b0) begin
			check_word("readdata", rd_q.pop_front(), rdata);
		end
		if (svc === 1'b1) begin
			svc_cnt++;
			check_vec(vq.size() > 0 ? vq.pop_front() : 14'h0000, vec);
		end
	end
	// ----------------
	// drivers
	// ----------------
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
		int n;
		@(posedge clk);
		if (!wr) rd_q.push_back(exp);
		avs_addr <= a;
		avs_wr <= wr;
		avs_rd <= !wr;
		avs_wd <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		if (n >= 50) timed_out();
		avs_rd <= 1'b0;
		avs_wr <= 1'b0;
	endtask
	task pulse(input logic [5:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 6'h00;
		@(posedge clk);
	endtask
	task automatic wait_rst(input logic v);
		int n;
		n = 0;
		while (cpu_rst !== v && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (n >= 100) timed_out();
	endtask
	task automatic wait_svc;
		int n;
		t++;
		n = 0;
		while (svc_cnt < t && n < 200) begin
			@(posedge clk);
			n++;
		end
		if (n >= 200) timed_out();
		repeat (8) @(posedge clk);
	endtask
	task automatic reset_cause(input logic [31:0] exp, input logic k);
		wait_rst(1'b1);
		check_word("keep_mode", {31'h0, k}, {31'h0, keep});
		wait_rst(1'b0);
		bus(1'b0, REG_RESET_CAUSE, 32'h0, exp);
	endtask
	// ----------------
	// scenarios
	// ----------------
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		repeat (POR + 8) @(posedge clk);
		check_word("cpu_reset", 32'h1, {31'h0, cpu_rst});
		pin_n <= 1'b1;
		wait_rst(1'b0);
		bus(1'b0, REG_TCS, 32'h0, {24'h0, TCS_RESET});
		bus(1'b0, 8'h1c, 32'h0, 32'h0);
		r = $random(seed);
		bus(1'b1, REG_TCS, r, 32'h0);
		avs_be <= 4'he;
		bus(1'b1, REG_TCS, 32'hff, 32'h0);
		avs_be <= 4'hf;
		bus(1'b0, REG_TCS, 32'h0, {24'h0, r[7:0] & TCS_CTL_MASK});
		check_word("rate", {30'h0, r[1:0]}, {30'h0, rate});
		bus(1'b1, REG_SYNC_CTL, 32'h80, 32'h0);
		bus(1'b1, REG_BUS_CTL, 32'h1, 32'h0);
		bus(1'b1, REG_TCS, 32'h20, 32'h0);
		irq_n <= 1'b0;
		sbus <= 1'b1;
		pulse(6'b011100);
		irq_n <= 1'b1;
		vq = '{VEC_EXT, VEC_SYNC, VEC_BUS, VEC_TIMER};
		for (int k = 1; k <= 4; k++) begin
			pulse(6'b000001);
			wait_svc();
			sbus <= (k == 3) ? 1'b0 : sbus;
			if (k == 4) bus(1'b1, REG_TCS, 32'h20, 32'h0);
		end
		bus(1'b0, REG_TCS, 32'h0, 32'h20);
		pulse(6'b000001);
		repeat (20) @(posedge clk);
		vq = '{VEC_EXT, VEC_EXT, VEC_SWI, VEC_EXT, VEC_SWI};
		irq_n <= 1'b0;
		wait_svc();
		pulse(6'b000001);
		wait_svc();
		irq_n <= 1'b1;
		repeat (8) @(posedge clk);
		pulse(6'b000001);
		repeat (20) @(posedge clk);
		pulse(6'b000010);
		wait_svc();
		bus(1'b1, REG_TCS, 32'h28, 32'h0);
		for (int k = 0; k < 2; k++) begin
			irq_n <= 1'b0;
			repeat (4) @(posedge clk);
			irq_n <= 1'b1;
			repeat (22) @(posedge clk);
		end
		pulse(6'b000001);
		wait_svc();
		pulse(6'b000010);
		wait_svc();
		pulse(6'b000001);
		repeat (20) @(posedge clk);
		vq = '{VEC_SYNC, VEC_SWI, VEC_SWI, VEC_SYNC};
		pulse(6'b000100);
		pulse(6'b000010);
		wait_svc();
		wait_svc();
		pulse(6'b000001);
		pulse(6'b000010);
		pulse(6'b000100);
		wait_svc();
		pulse(6'b000001);
		wait_svc();
		pulse(6'b000001);
		repeat (20) @(posedge clk);
		bus(1'b1, REG_SYNC_CTL, 32'h0, 32'h0);
		bus(1'b1, REG_BUS_CTL, 32'h0, 32'h0);
		sbus <= 1'b1;
		pulse(6'b000100);
		repeat (20) @(posedge clk);
		sbus <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			cpu_addr <= WDOG_SERVICE_ADDR;
			cpu_wdata <= k[7:0];
			cpu_wr <= 1'b1;
			@(posedge clk);
			cpu_wr <= 1'b0;
			@(posedge clk);
			check_word("watchdog_clear", {31'h0, k == 0}, {31'h0, wclr});
			repeat (2) @(posedge clk);
		end
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			fetch_addr <= 14'h0100 | r[13:0];
			fetch <= 1'b1;
			@(posedge clk);
			fetch <= 1'b0;
			@(posedge clk);
		end
		check_word("cpu_reset", 32'h0, {31'h0, cpu_rst});
		fetch_addr <= 14'h0010;
		fetch <= 1'b1;
		@(posedge clk);
		fetch <= 1'b0;
		reset_cause(32'h4, 1'b1);
		pulse(6'b100000);
		reset_cause(32'h8, 1'b1);
		pin_n <= 1'b0;
		repeat (3) @(posedge clk);
		pin_n <= 1'b1;
		reset_cause(32'h2, 1'b0);
		test_done();
	end
endmodule
